// ---- logic/scg_defines.svh ----
// offsets, field positions, reset values and timing counts of the clock block
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// write register addresses
`define SCG_OFS_AUX1_PLL 8'hab
`define SCG_OFS_AUX1_REF 8'hac
`define SCG_OFS_AUX2_PLL 8'had
`define SCG_OFS_AUX2_REF 8'hae

// pll config fields
`define SCG_PLL_MAIN_LSB 0
`define SCG_PLL_MAIN_MSB 9
`define SCG_PLL_VCO_LSB 10
`define SCG_PLL_VCO_MSB 15
// ref config fields, bits 12:9 reserved
`define SCG_REF_DIV_LSB 0
`define SCG_REF_DIV_MSB 8
`define SCG_REF_ROUTE_LSB 13
`define SCG_REF_ROUTE_MSB 14
`define SCG_REF_PSAVE_BIT 15

// reset values: output one bypassed and running, output two powersaved
`define SCG_PLL_CFG_RST 16'h0428
`define SCG_AUX1_REF_RST 16'h20c8
`define SCG_AUX2_REF_RST 16'h80c8

// clock setting entries
`define SCG_SET_ENTRIES 9
`define SCG_SET_SRC_IDX 4

// timing
`define SCG_CORE_KHZ 50000
`define SCG_CLK_PERIOD_NS 20
`define SCG_XTAL_MAX_KHZ 12288
`define SCG_EXT_MAX_KHZ 24576
`define SCG_MAIN_TX_KHZ 24576
`define SCG_MAIN_RX_KHZ 49152
`define SCG_REF_DEFAULT_KHZ 19200
`define SCG_SVC_LATENCY_US 250
`define SCG_RATE_WIN_NS 10000
`define SCG_RATE_WIN_CYC (`SCG_RATE_WIN_NS / `SCG_CLK_PERIOD_NS)
`define SCG_NCO_BITS 24

`endif

// ---- logic/scg_pkg.sv ----
// types shared by the clock generator files
`default_nettype none
package scg_pkg;
  typedef enum logic [1:0] {
    SCG_ROUTE_PLL = 2'h0,
    SCG_ROUTE_PASS = 2'h1,
    SCG_ROUTE_LOW = 2'h2,
    SCG_ROUTE_RSVD = 2'h3
  } scg_route_e;
  typedef logic [15:0] scg_word_t;
endpackage : scg_pkg
`default_nettype wire

// ---- logic/scg_aux_pll.sv ----
// one auxiliary clock synthesiser: ref divider, period lock, fractional nco
`timescale 1ns/100ps
`default_nettype none
module scg_aux_pll (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // reference
  input wire logic ref_tick_i,
  input wire logic crystal_input_i,
  // settings
  input wire logic [8:0] ref_div_i,
  input wire logic [9:0] main_div_i,
  input wire logic [5:0] vco_div_i,
  input wire scg_pkg::scg_route_e route_i,
  input wire logic powersave_i,
  // clock out
  output logic clk_o
);
  import scg_pkg::*;

  logic [8:0] rcnt_q;
  logic pfd_q;
  logic [15:0] pcnt_q;
  logic [15:0] period_q;
  logic [23:0] acc_q;
  logic [23:0] acc_sum;
  logic [23:0] thr;
  logic run;

  // divided reference, nominally the 96 kHz comparison rate
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || powersave_i)
    begin
      rcnt_q <= 9'h000;
      pfd_q <= 1'b0;
    end
    else if (ref_tick_i && (rcnt_q + 9'h001 >= ref_div_i))
    begin
      rcnt_q <= 9'h000;
      pfd_q <= 1'b1;
    end
    else
    begin
      rcnt_q <= rcnt_q + 9'(ref_tick_i);
      pfd_q <= 1'b0;
    end
  end

  // lock onto the comparison period in core cycles; saturates if too slow
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || powersave_i)
    begin
      pcnt_q <= 16'h0000;
      period_q <= 16'h0000;
    end
    else if (pfd_q)
    begin
      pcnt_q <= 16'h0001;
      period_q <= pcnt_q;
    end
    else if (pcnt_q != 16'hffff)
    begin
      pcnt_q <= pcnt_q + 16'h0001;
    end
  end

  // f_out = f_ref / ref_div * main_div / vco_div, two edges per cycle
  assign run = !powersave_i && route_i == SCG_ROUTE_PLL && period_q != 16'h0;
  assign acc_sum = acc_q + {13'h0000, main_div_i, 1'b0};
  assign thr = 24'(period_q) * 24'((vco_div_i == 6'h00) ? 6'h01 : vco_div_i);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !run)
      acc_q <= 24'h000000;
    else if (acc_sum >= thr)
      acc_q <= acc_sum - thr;
    else
      acc_q <= acc_sum;
  end

  // each output stops on its own powersave
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || powersave_i)
      clk_o <= 1'b0;
    else if (route_i == SCG_ROUTE_PASS)
      clk_o <= crystal_input_i;
    else if (run && acc_sum >= thr)
      clk_o <= !clk_o;
    else if (!run)
      clk_o <= 1'b0;
  end

  AST_PSAVE_QUIET: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) powersave_i |=> !clk_o)
    else $error("aux clock runs while powersaved");

endmodule : scg_aux_pll
`default_nettype wire

// ---- logic/scg_top.sv ----
// clock generation unit: reference check, main nco, dividers, aux clocks
`timescale 1ns/100ps
`default_nettype none
`include "scg_defines.svh"
module scg_top #(
  parameter logic [15:0] ADC_DIV = 16'h0028,
  parameter logic [15:0] DAC_DIV = 16'h0028,
  parameter logic [15:0] TIMER_DIV = 16'(`SCG_SVC_LATENCY_US *
    `SCG_REF_DEFAULT_KHZ / 1000),
  parameter logic [15:0] DSP_DIV = 16'h0002,
  parameter logic [3:0] SRC_SEL = 4'h9
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // reference pin and modes
  input wire logic crystal_input_i,
  input wire logic ext_ref_i,
  input wire logic rx_mode_i,
  input wire logic idle_i,
  // register writes from the host serial bus
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire scg_pkg::scg_word_t wr_data_i,
  // clock setting entries
  input wire logic clk_set_wr_i,
  input wire logic [3:0] clk_set_idx_i,
  input wire scg_pkg::scg_word_t clk_set_data_i,
  // clocks and status
  output logic main_tick_o,
  output logic adc_tick_o,
  output logic dac_tick_o,
  output logic timer_tick_o,
  output logic dsp_tick_o,
  output logic bus_service_o,
  output logic ref_rate_fault_o,
  output logic aux_clock_out_one_o,
  output logic aux_clock_out_two_o
);
  import scg_pkg::*;

  localparam int NDIV = 4;
  localparam logic [15:0] XTAL_LIM =
    16'(`SCG_XTAL_MAX_KHZ * `SCG_RATE_WIN_NS / 1000000);
  localparam logic [15:0] EXT_LIM =
    16'(`SCG_EXT_MAX_KHZ * `SCG_RATE_WIN_NS / 1000000);
  localparam logic [15:0] WIN_LAST = 16'(`SCG_RATE_WIN_CYC - 1);

  function automatic logic [23:0] nco_inc(input int khz);
    nco_inc = 24'((64'(khz) << `SCG_NCO_BITS) / 64'(`SCG_CORE_KHZ));
  endfunction : nco_inc

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_en_i && wr_addr_i == ofs;
  endfunction : hit

  localparam logic [23:0] TX_INC = nco_inc(`SCG_MAIN_TX_KHZ);
  localparam logic [23:0] RX_INC = nco_inc(`SCG_MAIN_RX_KHZ);

  logic xtal_q;
  logic ref_tick;
  logic [15:0] win_q;
  logic [15:0] edges_q;
  logic [24:0] nco_sum;
  logic [23:0] nco_q;
  logic [15:0] div_set_q [NDIV];
  logic [3:0] src_q;
  logic [15:0] div_cnt_q [NDIV];
  logic [NDIV-1:0] div_tick;
  scg_word_t pll_cfg_q [2];
  scg_word_t ref_cfg_q [2];
  logic [1:0] aux_clk;

  // the crystal pin carries either the oscillator or an external clock
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      xtal_q <= 1'b0;
    else
      xtal_q <= crystal_input_i;
  end
  assign ref_tick = crystal_input_i && !xtal_q;

  // count reference edges per window against the source's limit
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      win_q <= 16'h0000;
      edges_q <= 16'h0000;
      ref_rate_fault_o <= 1'b0;
    end
    else if (win_q == WIN_LAST)
    begin
      win_q <= 16'h0000;
      edges_q <= 16'h0000;
      ref_rate_fault_o <= edges_q > (ext_ref_i ? EXT_LIM : XTAL_LIM);
    end
    else
    begin
      win_q <= win_q + 16'h0001;
      edges_q <= edges_q + 16'(ref_tick);
    end
  end

  // main clock as an nco; carry marks each main clock cycle
  assign nco_sum = {1'b0, nco_q} + {1'b0, rx_mode_i ? RX_INC : TX_INC};
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      nco_q <= 24'h000000;
      main_tick_o <= 1'b0;
    end
    else
    begin
      nco_q <= nco_sum[23:0];
      main_tick_o <= nco_sum[24];
    end
  end

  // clock setting entries: dividers 0..3, then source select
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      div_set_q[0] <= ADC_DIV;
      div_set_q[1] <= DAC_DIV;
      div_set_q[2] <= TIMER_DIV;
      div_set_q[3] <= DSP_DIV;
      src_q <= SRC_SEL;
    end
    else if (clk_set_wr_i && clk_set_idx_i < 4'(NDIV))
      div_set_q[clk_set_idx_i[1:0]] <= clk_set_data_i;
    else if (clk_set_wr_i && clk_set_idx_i == 4'(`SCG_SET_SRC_IDX))
      src_q <= clk_set_data_i[NDIV-1:0];
  end

  // src bit high: divide main clock, low: divide reference
  for (genvar i = 0; i < NDIV; i++)
  begin : g_div
    logic src_tick;
    assign src_tick = src_q[i] ? main_tick_o : ref_tick;
    assign div_tick[i] = src_tick &&
      (div_cnt_q[i] + 16'h0001 >= div_set_q[i]);
    always_ff @(posedge core_clk_i)
    begin
      if (sys_rst_i || div_tick[i])
        div_cnt_q[i] <= 16'h0000;
      else if (src_tick)
        div_cnt_q[i] <= div_cnt_q[i] + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      adc_tick_o <= 1'b0;
      dac_tick_o <= 1'b0;
      timer_tick_o <= 1'b0;
      dsp_tick_o <= 1'b0;
    end
    else
    begin
      adc_tick_o <= div_tick[0];
      dac_tick_o <= div_tick[1];
      timer_tick_o <= div_tick[2];
      dsp_tick_o <= div_tick[3];
    end
  end

  // idle: bus only serviced on timer ticks, so latency tracks its divider
  assign bus_service_o = idle_i ? timer_tick_o : 1'b1;

  // write-only aux registers
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pll_cfg_q[0] <= `SCG_PLL_CFG_RST;
      pll_cfg_q[1] <= `SCG_PLL_CFG_RST;
      ref_cfg_q[0] <= `SCG_AUX1_REF_RST;
      ref_cfg_q[1] <= `SCG_AUX2_REF_RST;
    end
    else
    begin
      if (hit(`SCG_OFS_AUX1_PLL))
        pll_cfg_q[0] <= wr_data_i;
      if (hit(`SCG_OFS_AUX2_PLL))
        pll_cfg_q[1] <= wr_data_i;
      if (hit(`SCG_OFS_AUX1_REF))
        ref_cfg_q[0] <= wr_data_i;
      if (hit(`SCG_OFS_AUX2_REF))
        ref_cfg_q[1] <= wr_data_i;
    end
  end

  // one synthesiser per output
  for (genvar k = 0; k < 2; k++)
  begin : g_aux
    scg_aux_pll u_pll (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ref_tick_i(ref_tick),
      .crystal_input_i(crystal_input_i),
      .ref_div_i(ref_cfg_q[k][`SCG_REF_DIV_MSB:`SCG_REF_DIV_LSB]),
      .main_div_i(pll_cfg_q[k][`SCG_PLL_MAIN_MSB:`SCG_PLL_MAIN_LSB]),
      .vco_div_i(pll_cfg_q[k][`SCG_PLL_VCO_MSB:`SCG_PLL_VCO_LSB]),
      .route_i(scg_route_e'(
        ref_cfg_q[k][`SCG_REF_ROUTE_MSB:`SCG_REF_ROUTE_LSB])),
      .powersave_i(ref_cfg_q[k][`SCG_REF_PSAVE_BIT]),
      .clk_o(aux_clk[k])
    );
  end
  assign aux_clock_out_one_o = aux_clk[0];
  assign aux_clock_out_two_o = aux_clk[1];

  sequence s_wr(logic [7:0] ofs);
    wr_en_i && wr_addr_i == ofs;
  endsequence

  sequence s_rst_end;
    $fell(sys_rst_i);
  endsequence

  AST_PLL1_WRITE: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) s_wr(`SCG_OFS_AUX1_PLL) |=>
    pll_cfg_q[0] == $past(wr_data_i))
    else $error("pll config one not updated");

  AST_REF2_WRITE: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) s_wr(`SCG_OFS_AUX2_REF) |=>
    ref_cfg_q[1] == $past(wr_data_i))
    else $error("ref config two not updated");

  AST_AUX1_BYPASS: assert property (@(posedge core_clk_i)
    s_rst_end |-> ref_cfg_q[0] == `SCG_AUX1_REF_RST ##1
    aux_clock_out_one_o == $past(crystal_input_i))
    else $error("output one not passing crystal after reset");

  AST_DEFAULT_DIV: assert property (@(posedge core_clk_i)
    s_rst_end |-> div_set_q[2] == TIMER_DIV && src_q == SRC_SEL)
    else $error("divider defaults wrong after reset");

  // steady transmit only: a receive carry may be followed at once
  AST_TX_RATE: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !rx_mode_i ##1 (main_tick_o && !rx_mode_i) ##1
    !rx_mode_i |-> !main_tick_o)
    else $error("transmit main clock too fast");

  AST_TIMER_SRC: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) div_tick[2] |->
    (src_q[2] ? main_tick_o : ref_tick) ##1 timer_tick_o)
    else $error("timer tick without source tick");

  AST_IDLE_SVC: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) (idle_i && bus_service_o) |->
    $past(div_tick[2]))
    else $error("idle bus service off timer");

  AST_FAULT_WIN: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) $changed(ref_rate_fault_o) |->
    win_q == 16'h0000)
    else $error("rate fault moved outside window end");

endmodule : scg_top
`default_nettype wire

// ---- testbench/scg_host_model.sv ----
// host side model: register and clock setting writes
`timescale 1ns/100ps
`default_nettype none
module scg_host_model (
  // clock
  input wire logic core_clk_i,
  // register writes
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output scg_pkg::scg_word_t wr_data_o,
  // clock setting writes
  output logic clk_set_wr_o,
  output logic [3:0] clk_set_idx_o,
  output scg_pkg::scg_word_t clk_set_data_o
);
  import scg_pkg::*;
  initial
  begin
    wr_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 16'h0000;
    clk_set_wr_o = 1'b0;
    clk_set_idx_o = 4'h0;
    clk_set_data_o = 16'h0000;
  end
  // released lines go inverted so stale values cannot pass for valid
  task automatic write_reg(input logic [7:0] a,
    input scg_word_t d);
    @(posedge core_clk_i);
    #1;
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(posedge core_clk_i);
    #1;
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask : write_reg
  task automatic write_set(input logic [3:0] i, input scg_word_t d);
    @(posedge core_clk_i);
    #1;
    clk_set_wr_o = 1'b1;
    clk_set_idx_o = i;
    clk_set_data_o = d;
    @(posedge core_clk_i);
    #1;
    clk_set_wr_o = 1'b0;
    clk_set_idx_o = ~i;
    clk_set_data_o = ~d;
  endtask : write_set
endmodule : scg_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the clock generation unit
`timescale 1ns/100ps
`default_nettype none
`include "scg_defines.svh"
module tb;
  import scg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic crystal = 1'b0;
  logic ext_ref = 1'b0;
  logic rx_mode = 1'b0;
  logic idle = 1'b0;
  logic wr_en, clk_set_wr;
  logic [7:0] wr_addr;
  logic [3:0] clk_set_idx;
  scg_word_t wr_data, clk_set_data;
  logic main_tick, timer_tick, bus_svc, fault, aux1, aux2;
  logic adc_tick, dac_tick, dsp_tick;
  logic xtal_q = 1'b0;
  logic aux1_q = 1'b0;
  logic aux2_q = 1'b0;
  int half = 4;
  int hcnt = 0;
  int failures = 0;
  int comparisons = 0;
  int c_main, c_tmr, c_svc, c_a1, c_a2, mis1, mis2;
  int c_adc, c_dac, c_dsp;
  // main ticks expected in a 2560-cycle window
  localparam int TX_TICKS = `SCG_MAIN_TX_KHZ * 2560 / `SCG_CORE_KHZ;
  localparam int RX_TICKS = `SCG_MAIN_RX_KHZ * 2560 / `SCG_CORE_KHZ;
  always #10 core_clk = ~core_clk;
  // reference pin: ref tick every 2*half cycles
  always @(posedge core_clk)
  begin
    #1;
    hcnt++;
    if (hcnt >= half)
    begin
      hcnt = 0;
      crystal = ~crystal;
    end
  end
  always @(posedge core_clk)
  begin
    c_main += (main_tick === 1'b1);
    c_tmr += (timer_tick === 1'b1);
    c_svc += (bus_svc === 1'b1);
    c_adc += (adc_tick === 1'b1);
    c_dac += (dac_tick === 1'b1);
    c_dsp += (dsp_tick === 1'b1);
    c_a1 += (aux1 === 1'b1 && aux1_q === 1'b0);
    c_a2 += (aux2 === 1'b1 && aux2_q === 1'b0);
    mis1 += (aux1 !== xtal_q);
    mis2 += (aux2 !== xtal_q);
    xtal_q <= crystal;
    aux1_q <= aux1;
    aux2_q <= aux2;
  end
  scg_host_model host (
    .core_clk_i(core_clk), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .clk_set_wr_o(clk_set_wr),
    .clk_set_idx_o(clk_set_idx), .clk_set_data_o(clk_set_data)
  );
  // small timer divider keeps windows short; all dividers fed by ref
  scg_top #(.TIMER_DIV(16'h0010), .SRC_SEL(4'h0)) dut (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .crystal_input_i(crystal),
    .ext_ref_i(ext_ref), .rx_mode_i(rx_mode), .idle_i(idle),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .clk_set_wr_i(clk_set_wr), .clk_set_idx_i(clk_set_idx),
    .clk_set_data_i(clk_set_data), .main_tick_o(main_tick),
    .adc_tick_o(adc_tick), .dac_tick_o(dac_tick), .timer_tick_o(timer_tick),
    .dsp_tick_o(dsp_tick), .bus_service_o(bus_svc), .ref_rate_fault_o(fault),
    .aux_clock_out_one_o(aux1), .aux_clock_out_two_o(aux2)
  );
  task automatic chk(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  function automatic bit near(input int v, input int e, input int tol);
    return (v >= e - tol) && (v <= e + tol);
  endfunction : near
  task automatic window(input int n);
    @(posedge core_clk);
    #1;
    c_main = 0;
    c_tmr = 0;
    c_svc = 0;
    c_a1 = 0;
    c_a2 = 0;
    mis1 = 0;
    mis2 = 0;
    c_adc = 0;
    c_dac = 0;
    c_dsp = 0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask : window
  task automatic close_out();
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic wait_rise2();
    int n;
    n = 0;
    while (!(aux2 === 1'b1) && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      $display("BAD %0t aux two never started", $time);
      close_out();
    end
  endtask : wait_rise2
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    window(2560);
    chk(near(c_main, TX_TICKS, 2), "tx main rate");
    chk(near(c_tmr, 20, 1), "timer rate");
    chk(near(c_adc, 8, 1) && near(c_dac, 8, 1), "converter rates");
    chk(near(c_dsp, 160, 1), "processor rate");
    chk(c_svc == 2560, "service not idle");
    chk(mis1 == 0 && c_a1 > 300, "aux one pass-through");
    chk(c_a2 == 0 && aux2 === 1'b0, "aux two off");
    chk(fault === 1'b0, "fault at slow ref");
    rx_mode = 1'b1;
    idle = 1'b1;
    window(2560);
    chk(near(c_main, RX_TICKS, 2), "rx main rate");
    chk(c_svc == c_tmr && near(c_tmr, 20, 1), "idle service pacing");
    rx_mode = 1'b0;
    host.write_set(4'h2, 16'h0004);
    window(2560);
    chk(near(c_tmr, 80, 1), "timer div 4");
    host.write_set(4'h7, 16'h0001);
    host.write_set(4'h4, 16'h0004);
    window(2560);
    chk(near(c_tmr, 315, 2), "timer from main");
    chk(near(c_dsp, 160, 1), "entry seven refused");
    half = 2;
    repeat (1100) @(posedge core_clk);
    #1;
    chk(fault === 1'b1, "crystal too fast");
    ext_ref = 1'b1;
    repeat (1100) @(posedge core_clk);
    #1;
    chk(fault === 1'b0, "external ok");
    half = 4;
    host.write_reg(`SCG_OFS_AUX2_REF, 16'h2001);
    host.write_reg(8'haf, 16'h8000);
    wait_rise2();
    window(800);
    chk(mis2 == 0, "aux two pass-through");
    host.write_reg(`SCG_OFS_AUX1_PLL, 16'h1002);
    host.write_reg(`SCG_OFS_AUX1_REF, 16'h0004);
    repeat (1000) @(posedge core_clk);
    window(6400);
    chk(near(c_a1, 100, 3), "aux one pll rate");
    host.write_reg(`SCG_OFS_AUX1_REF, 16'h8004);
    repeat (10) @(posedge core_clk);
    window(800);
    chk(c_a1 == 0 && aux1 === 1'b0, "aux one powersaved");
    chk(mis2 == 0, "aux two unaffected");
    host.write_reg(`SCG_OFS_AUX2_PLL, 16'h0802);
    host.write_reg(`SCG_OFS_AUX2_REF, 16'h0004);
    repeat (1000) @(posedge core_clk);
    window(3200);
    chk(near(c_a2, 100, 3), "aux two pll rate");
    chk(c_a1 == 0 && aux1 === 1'b0, "aux one stays off");
    host.write_reg(`SCG_OFS_AUX2_REF, 16'h4004);
    window(400);
    chk(c_a2 == 0 && aux2 === 1'b0, "aux two held low");
    close_out();
  end
endmodule : tb
`default_nettype wire
